// File: hdl/docm_params.svh
`ifndef DOCM_PARAMS_SVH
`define DOCM_PARAMS_SVH

// ****************************************************************
// Clock and time base.
// ****************************************************************
`define DOCM_CLK_PERIOD_NS    20
`define DOCM_TENTH_SEC_NS     100000000
`define DOCM_TENTHS_PER_MIN   6'd60

// ****************************************************************
// Output function codes.
// ****************************************************************
`define DOCM_FN_NULL          6'h00
`define DOCM_FN_FREQ_ARRIVAL  6'h01
`define DOCM_FN_FREQ_THRESH   6'h02
`define DOCM_FN_UPPER_ARRIVAL 6'h03
`define DOCM_FN_LOWER_ARRIVAL 6'h04
`define DOCM_FN_COUNT_ARRIVAL 6'h05
`define DOCM_FN_TIMING_ARRIVE 6'h06
`define DOCM_FN_RUN_TIME      6'h0f
`define DOCM_FN_TORQUE        6'h10
`define DOCM_FN_UNDERLOAD     6'h23

// ****************************************************************
// Setting limits (freq 0.01 Hz, time 0.1 s, torque 0.1 %).
// ****************************************************************
`define DOCM_BAND_MAX         16'h03e8
`define DOCM_LAG_MAX          16'h03e8
`define DOCM_DELAY_MAX        10'h3e8
`define DOCM_COUNT_MAX        14'h270f
`define DOCM_TIMING_MAX       16'hfffa
`define DOCM_UL_THR_MAX       12'h7d0

// ****************************************************************
// Setting defaults, for the integrator's reference.
// ****************************************************************
`define DOCM_BAND_DFLT        16'h00fa
`define DOCM_LEVEL_DFLT       16'h1388
`define DOCM_LAG_DFLT         16'h0064
`define DOCM_DELAY_DFLT       10'h000
`define DOCM_UL_THR_DFLT      12'h064
`define DOCM_UL_DELAY_DFLT    10'h032
`define DOCM_OPTIME_DFLT      16'hfffa

// ****************************************************************
// Torque release fraction: release below 4/5 of the reference.
// ****************************************************************
`define DOCM_TRQ_REL_NUM      3'h4
`define DOCM_TRQ_REL_DEN      3'h5

`endif

// File: hdl/docm_pkg.sv
`include "docm_params.svh"

package docm_pkg;
    typedef logic [15:0] docm_freq_t;
    typedef logic [11:0] docm_torque_t;
    typedef logic [9:0]  docm_delay_t;
    typedef logic [5:0]  docm_func_t;
endpackage : docm_pkg

// File: hdl/docm_delay_timer.sv
`timescale 1ns/1ns
`include "docm_params.svh"

module docm_delay_timer
    import docm_pkg::*;
#(
    parameter int DW = 10
) (
    input  wire logic          mclk,
    input  wire logic          rst_b,
    input  wire logic          tick,
    input  wire logic          cond,
    input  wire logic [DW-1:0] delay,
    output logic               active
);

    logic [DW-1:0] cnt_r;
    logic          active_r;
    logic          done;

    // Elapsed once the tick count has caught up with the delay.
    assign done   = (cnt_r >= delay);
    assign active = active_r;

    // ****************************************************************
    // Tick counter.
    // ****************************************************************
    // A lapse of the condition restarts the delay from zero.
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            cnt_r <= '0;
        end else if (!cond) begin
            cnt_r <= '0;
        end else if (tick && !done) begin
            cnt_r <= cnt_r + 1'b1;
        end
    end

    // Output follows the condition only once the delay has elapsed.
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            active_r <= 1'b0;
        end else begin
            active_r <= cond && done;
        end
    end

    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_b);

    a_timer_restart: assert property (!cond |=> (cnt_r == '0) && !active_r)
        else $error("delay timer did not restart when its condition lapsed");
    a_timer_early: assert property ((cond && cnt_r < delay) |=> !active_r)
        else $error("delayed output went active before its delay elapsed");

endmodule : docm_delay_timer

// File: hdl/docm_top.sv
`timescale 1ns/1ns
`include "docm_params.svh"

// What this block does
// - Two outputs, each selecting any condition.
// - Frequency arrival within band around set frequency.
// - Threshold output sets when frequency reaches level.
// - Threshold output holds until level minus lag.
// - Upper/lower limit arrival delayed by own timers.
// - Torque sets at reference, clears below 80%.
// - Count arrival when counter reaches setting.
// - Timing arrival when timing equals setting.
// - Unit selectable; timing cleared while disabled.
// - Run time arrival at preset operating hours.
// - Underload threshold 0..200.0 percent of rated.
// - Underload output active after delay below threshold.
// - Underload clears once torque exceeds threshold.
module docm_top
    import docm_pkg::*;
#(
    parameter int TICK_CYC = `DOCM_TENTH_SEC_NS / `DOCM_CLK_PERIOD_NS
) (
    input  wire logic         mclk,
    input  wire logic         rst_b,
    input  wire docm_freq_t   out_freq,
    input  wire docm_freq_t   set_freq,
    input  wire docm_freq_t   upper_limit_freq,
    input  wire docm_freq_t   lower_limit_freq,
    input  wire docm_torque_t out_torque,
    input  wire docm_torque_t torque_reference,
    input  wire logic [13:0]  counter_value,
    input  wire logic [15:0]  operating_hours,
    input  wire logic         timing_enable,
    input  wire logic         timing_unit_min,
    input  wire docm_freq_t   arrival_band_width,
    input  wire docm_freq_t   threshold_level,
    input  wire docm_freq_t   threshold_lag,
    input  wire docm_delay_t  upper_arrival_delay,
    input  wire docm_delay_t  lower_arrival_delay,
    input  wire logic [13:0]  count_arrival_setting,
    input  wire logic [15:0]  timing_arrival_setting,
    input  wire logic [15:0]  preset_operating_time,
    input  wire docm_torque_t underload_threshold,
    input  wire docm_delay_t  underload_delay,
    input  wire docm_func_t   do_function,
    input  wire docm_func_t   relay_function,
    output logic              do_out,
    output logic              relay_out,
    output logic [15:0]       timing_value
);

    // ****************************************************************
    // Settings clamped to their ranges.
    // ****************************************************************
    docm_freq_t   band;
    docm_freq_t   lag;
    docm_delay_t  up_dly;
    docm_delay_t  lo_dly;
    docm_delay_t  ul_dly;
    logic [13:0]  cnt_set;
    logic [15:0]  tim_set;
    docm_torque_t ul_thr;

    // Out-of-range settings saturate rather than wrap, so a bad value cannot invert a test.
    assign band    = (arrival_band_width > `DOCM_BAND_MAX) ? `DOCM_BAND_MAX : arrival_band_width;
    assign lag     = (threshold_lag > `DOCM_LAG_MAX) ? `DOCM_LAG_MAX : threshold_lag;
    assign up_dly  = (upper_arrival_delay > `DOCM_DELAY_MAX) ? `DOCM_DELAY_MAX
                                                               : upper_arrival_delay;
    assign lo_dly  = (lower_arrival_delay > `DOCM_DELAY_MAX) ? `DOCM_DELAY_MAX
                                                               : lower_arrival_delay;
    assign ul_dly  = (underload_delay > `DOCM_DELAY_MAX) ? `DOCM_DELAY_MAX : underload_delay;
    assign cnt_set = (count_arrival_setting > `DOCM_COUNT_MAX) ? `DOCM_COUNT_MAX
                                                                 : count_arrival_setting;
    assign tim_set = (timing_arrival_setting > `DOCM_TIMING_MAX) ? `DOCM_TIMING_MAX
                                                                   : timing_arrival_setting;
    assign ul_thr  = (underload_threshold > `DOCM_UL_THR_MAX) ? `DOCM_UL_THR_MAX
                                                                : underload_threshold;

    // ****************************************************************
    // Tenth-of-a-second time base.
    // ****************************************************************
    logic [31:0] tick_cnt_r;
    logic        tick;

    assign tick = (tick_cnt_r == 32'(TICK_CYC - 1));

    // Free-running prescaler shared by every delay and by the timing accumulator.
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            tick_cnt_r <= '0;
        end else if (tick) begin
            tick_cnt_r <= '0;
        end else begin
            tick_cnt_r <= tick_cnt_r + 32'h0000_0001;
        end
    end

    // ****************************************************************
    // Frequency arrival and frequency threshold.
    // ****************************************************************
    logic [16:0] freq_diff;
    logic        in_band;
    logic [16:0] release_freq;
    logic        freq_arrival_r;
    logic        freq_threshold_detect_r;

    assign freq_diff    = (out_freq >= set_freq) ? {1'b0, out_freq} - {1'b0, set_freq}
                                                 : {1'b0, set_freq} - {1'b0, out_freq};
    assign in_band      = (freq_diff <= {1'b0, band});
    // Release point saturates at zero so a lag above the level never wraps.
    assign release_freq = (threshold_level > lag) ? {1'b0, threshold_level} - {1'b0, lag}
                                                  : 17'h0_0000;

    // Window test is symmetric: both band edges count as arrived.
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            freq_arrival_r <= 1'b0;
        end else begin
            freq_arrival_r <= in_band;
        end
    end

    // Hysteresis: set at the level, held until the release point is reached.
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            freq_threshold_detect_r <= 1'b0;
        end else if (out_freq >= threshold_level) begin
            freq_threshold_detect_r <= 1'b1;
        end else if ({1'b0, out_freq} <= release_freq) begin
            freq_threshold_detect_r <= 1'b0;
        end
    end

    // ****************************************************************
    // Upper and lower limit arrival with delays.
    // ****************************************************************
    logic upper_limit_freq_arrival;
    logic lower_limit_freq_arrival;

    docm_delay_timer #(
        .DW     (10)
    ) u_upper_delay (
        .mclk   (mclk),
        .rst_b  (rst_b),
        .tick   (tick),
        .cond   (out_freq >= upper_limit_freq),
        .delay  (up_dly),
        .active (upper_limit_freq_arrival)
    );

    docm_delay_timer #(
        .DW     (10)
    ) u_lower_delay (
        .mclk   (mclk),
        .rst_b  (rst_b),
        .tick   (tick),
        .cond   (out_freq <= lower_limit_freq),
        .delay  (lo_dly),
        .active (lower_limit_freq_arrival)
    );

    // ****************************************************************
    // Torque detection and underload.
    // ****************************************************************
    logic [14:0] trq_scaled;
    logic [14:0] ref_scaled;
    logic        torque_detect_r;
    logic        ul_cond_r;
    logic        underload_active;

    assign trq_scaled = 15'(out_torque) * 15'(`DOCM_TRQ_REL_DEN);
    assign ref_scaled = 15'(torque_reference) * 15'(`DOCM_TRQ_REL_NUM);

    // Between 80 % and 100 % of the reference the output keeps its state.
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            torque_detect_r <= 1'b0;
        end else if (out_torque >= torque_reference) begin
            torque_detect_r <= 1'b1;
        end else if (trq_scaled < ref_scaled) begin
            torque_detect_r <= 1'b0;
        end
    end

    // Torque exactly at the threshold keeps the present state, avoiding chatter.
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            ul_cond_r <= 1'b0;
        end else if (out_torque > ul_thr) begin
            ul_cond_r <= 1'b0;
        end else if (out_torque < ul_thr) begin
            ul_cond_r <= 1'b1;
        end
    end

    docm_delay_timer #(
        .DW     (10)
    ) u_underload_delay (
        .mclk   (mclk),
        .rst_b  (rst_b),
        .tick   (tick),
        .cond   (ul_cond_r),
        .delay  (ul_dly),
        .active (underload_active)
    );

    // ****************************************************************
    // Timing accumulator, count and run-time arrival.
    // ****************************************************************
    logic [5:0]  min_pre_r;
    logic        unit_tick;
    logic [15:0] timing_r;
    logic        count_arrival_r;
    logic        timing_arrival_r;
    logic        run_time_arrival_r;

    assign unit_tick    = tick && (!timing_unit_min || (min_pre_r == `DOCM_TENTHS_PER_MIN - 1'b1));
    assign timing_value = timing_r;

    // Minute prescaler counts tenths; it restarts with the accumulator.
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            min_pre_r <= '0;
        end else if (!timing_enable || !timing_unit_min) begin
            min_pre_r <= '0;
        end else if (tick) begin
            min_pre_r <= (min_pre_r == `DOCM_TENTHS_PER_MIN - 1'b1) ? 6'h00 : min_pre_r + 1'b1;
        end
    end

    // Accumulates in tenths of the chosen unit and saturates at the top of its range.
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            timing_r <= '0;
        end else if (!timing_enable) begin
            timing_r <= '0;
        end else if (unit_tick && timing_r < `DOCM_TIMING_MAX) begin
            timing_r <= timing_r + 16'h0001;
        end
    end

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            count_arrival_r    <= 1'b0;
            timing_arrival_r   <= 1'b0;
            run_time_arrival_r <= 1'b0;
        end else begin
            count_arrival_r    <= (counter_value >= cnt_set);
            timing_arrival_r   <= (timing_r == tim_set);
            run_time_arrival_r <= (operating_hours >= preset_operating_time);
        end
    end

    // ****************************************************************
    // Output selection.
    // ****************************************************************
    function automatic logic pick(input docm_func_t fn,
                                  input logic [8:0] c);
        logic r;
        r = 1'b0;
        case (fn)
            `DOCM_FN_FREQ_ARRIVAL:  r = c[0];
            `DOCM_FN_FREQ_THRESH:   r = c[1];
            `DOCM_FN_UPPER_ARRIVAL: r = c[2];
            `DOCM_FN_LOWER_ARRIVAL: r = c[3];
            `DOCM_FN_COUNT_ARRIVAL: r = c[4];
            `DOCM_FN_TIMING_ARRIVE: r = c[5];
            `DOCM_FN_RUN_TIME:      r = c[6];
            `DOCM_FN_TORQUE:        r = c[7];
            `DOCM_FN_UNDERLOAD:     r = c[8];
            default:                r = 1'b0;
        endcase
        return r;
    endfunction : pick

    logic [8:0] cond_vec;
    logic       do_r;
    logic       relay_r;

    assign cond_vec  = {underload_active, torque_detect_r, run_time_arrival_r,
                        timing_arrival_r, count_arrival_r, lower_limit_freq_arrival,
                        upper_limit_freq_arrival, freq_threshold_detect_r, freq_arrival_r};
    assign do_out    = do_r;
    assign relay_out = relay_r;

    // Both terminals select independently; unknown or reserved codes read inactive.
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            do_r    <= 1'b0;
            relay_r <= 1'b0;
        end else begin
            do_r    <= pick(do_function, cond_vec);
            relay_r <= pick(relay_function, cond_vec);
        end
    end

    // ****************************************************************
    // Checks.
    // ****************************************************************
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_b);

    sequence s_ul_rise;
        out_torque > ul_thr;
    endsequence

    sequence s_ul_gone;
        !ul_cond_r ##1 !underload_active;
    endsequence

    a_arrival_window: assert property (in_band |=> freq_arrival_r)
        else $error("frequency arrival missing inside band");
    a_thresh_set: assert property (out_freq >= threshold_level |=> freq_threshold_detect_r)
        else $error("threshold output not set at level");
    a_thresh_hold: assert property (freq_threshold_detect_r
                                    && {1'b0, out_freq} > release_freq
                                    |=> freq_threshold_detect_r)
        else $error("threshold output dropped above release point");
    a_trq_release: assert property (torque_detect_r && out_torque < torque_reference
                                    && trq_scaled >= ref_scaled |=> torque_detect_r)
        else $error("torque output dropped above 80 percent");
    a_count_arrive: assert property (counter_value >= cnt_set |=> count_arrival_r)
        else $error("count arrival missing");
    a_timing_equal: assert property (timing_r != tim_set |=> !timing_arrival_r)
        else $error("timing arrival without equality");
    a_timing_clear: assert property (!timing_enable |=> timing_r == 16'h0000)
        else $error("timing value not cleared while disabled");
    a_run_time: assert property (operating_hours < preset_operating_time
                                 |=> !run_time_arrival_r)
        else $error("run time arrival too early");
    a_ul_clear: assert property (s_ul_rise |=> s_ul_gone)
        else $error("underload did not clear above threshold");
    a_do_select: assert property (##1 do_out == pick($past(do_function), $past(cond_vec)))
        else $error("digital output does not follow its selection");
    a_relay_select: assert property ($stable(relay_function) && $stable(cond_vec)
                                     |=> relay_out == pick($past(relay_function),
                                                           $past(cond_vec)))
        else $error("relay output does not follow its selection");

endmodule : docm_top

// File: testbench/docm_terminal_reader.sv
`timescale 1ns/1ns

// ****************************************************************
// Controller-side reader of the two output terminals.
// ****************************************************************
module docm_terminal_reader (
    input  wire logic       mclk,
    input  wire logic       rst_b,
    input  wire logic       do_out,
    input  wire logic       relay_out,
    output logic [7:0]      do_edges,
    output logic [7:0]      relay_edges
);
    logic do_prev_r;
    logic relay_prev_r;

    // Counting rising edges exposes chatter that a level check misses.
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            do_prev_r    <= 1'b0;
            relay_prev_r <= 1'b0;
            do_edges     <= 8'h00;
            relay_edges  <= 8'h00;
        end else begin
            do_prev_r    <= do_out;
            relay_prev_r <= relay_out;
            if (do_out && !do_prev_r) begin
                do_edges <= do_edges + 8'h01;
            end
            if (relay_out && !relay_prev_r) begin
                relay_edges <= relay_edges + 8'h01;
            end
        end
    end
endmodule : docm_terminal_reader

// File: testbench/test_docm_top.sv
`timescale 1ns/1ns
`include "docm_params.svh"

module test_docm_top;
    import docm_pkg::*;

    // ****************************************************************
    // Signals and instances.
    // ****************************************************************
    logic         mclk = 1'b0;
    logic         rst_b = 1'b0;
    docm_freq_t   out_freq = 16'h0000, set_freq = 16'h1388;
    docm_freq_t   upper_limit_freq = 16'h1770, lower_limit_freq = 16'h03e8;
    docm_torque_t out_torque = 12'h1f4, torque_reference = 12'h3e8;
    logic [13:0]  counter_value = 14'h0000, count_arrival_setting = 14'h270f;
    logic [15:0]  operating_hours = 16'h0000, preset_operating_time = 16'hfffa;
    logic         timing_enable = 1'b0, timing_unit_min = 1'b0;
    docm_freq_t   arrival_band_width = 16'h00fa, threshold_level = 16'h1388;
    docm_freq_t   threshold_lag = 16'h0064;
    docm_delay_t  upper_arrival_delay = 10'h005, lower_arrival_delay = 10'h005;
    docm_delay_t  underload_delay = 10'h005;
    logic [15:0]  timing_arrival_setting = 16'h0003;
    docm_torque_t underload_threshold = 12'h064;
    docm_func_t   do_function = 6'h00, relay_function = 6'h00;
    logic         do_out, relay_out;
    logic [15:0]  timing_value;
    logic [7:0]   do_edges, relay_edges;
    int           mismatches = 0, checks = 0;

    // A short tick keeps the delay scenarios to tens of cycles.
    docm_top #(.TICK_CYC(10)) dut (.mclk(mclk), .rst_b(rst_b), .out_freq(out_freq),
        .set_freq(set_freq), .upper_limit_freq(upper_limit_freq),
        .lower_limit_freq(lower_limit_freq), .out_torque(out_torque),
        .torque_reference(torque_reference), .counter_value(counter_value),
        .operating_hours(operating_hours), .timing_enable(timing_enable),
        .timing_unit_min(timing_unit_min), .arrival_band_width(arrival_band_width),
        .threshold_level(threshold_level), .threshold_lag(threshold_lag),
        .upper_arrival_delay(upper_arrival_delay), .lower_arrival_delay(lower_arrival_delay),
        .count_arrival_setting(count_arrival_setting),
        .timing_arrival_setting(timing_arrival_setting),
        .preset_operating_time(preset_operating_time),
        .underload_threshold(underload_threshold), .underload_delay(underload_delay),
        .do_function(do_function), .relay_function(relay_function), .do_out(do_out),
        .relay_out(relay_out), .timing_value(timing_value));

    docm_terminal_reader reader (.mclk(mclk), .rst_b(rst_b), .do_out(do_out),
        .relay_out(relay_out), .do_edges(do_edges), .relay_edges(relay_edges));

    // The clock toggles every half period of 20 ns.
    always #10 mclk = ~mclk;

    // ****************************************************************
    // Shared tasks.
    // ****************************************************************
    task automatic final_report();
        $display("checks %0d mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : final_report

    task automatic check(input string name, input logic [15:0] exp, input logic [15:0] seen);
        checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("[ERR] %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    // Inputs move only at falling edges, away from the sampling edge.
    task automatic cyc(input int n);
        repeat (n) @(negedge mclk);
    endtask : cyc

    // ****************************************************************
    // Scenarios.
    // ****************************************************************
    task automatic scen_freq();
        logic [15:0] f [7] = '{16'h1388, 16'h1482, 16'h1483, 16'h1325, 16'h1324,
                               16'h1387, 16'h128d};
        logic [6:0]  ed = 7'h3b;
        logic [6:0]  er = 7'h0f;
        do_function    = 6'h01;
        relay_function = 6'h02;
        for (int i = 0; i < 7; i++) begin
            out_freq = f[i];
            cyc(4);
            check("do_out", ed[i], do_out);
            check("relay_out", er[i], relay_out);
        end
        check("do_edges", 16'h0002, do_edges);
        check("relay_edges", 16'h0001, relay_edges);
    endtask : scen_freq

    task automatic scen_torque_count();
        logic [11:0] t [5] = '{12'h3e7, 12'h3e8, 12'h320, 12'h31f, 12'h3e7};
        logic [4:0]  et = 5'h06;
        do_function    = 6'h10;
        relay_function = 6'h05;
        for (int i = 0; i < 5; i++) begin
            out_torque = t[i];
            counter_value = (i < 2) ? 14'h270e : 14'h270f;
            cyc(4);
            check("do_out", et[i], do_out);
            check("relay_out", (i < 2) ? 1'b0 : 1'b1, relay_out);
        end
        do_function    = 6'h0f;
        relay_function = 6'h07;
        operating_hours = 16'hfff9;
        cyc(4);
        check("do_out", 1'b0, do_out);
        check("relay_out", 1'b0, relay_out);
        operating_hours = 16'hfffa;
        cyc(4);
        check("do_out", 1'b1, do_out);
    endtask : scen_torque_count

    task automatic scen_limit_delay();
        do_function    = 6'h03;
        relay_function = 6'h04;
        out_freq = 16'h1770;
        cyc(35);
        out_freq = 16'h176f;
        cyc(2);
        out_freq = 16'h1770;
        cyc(25);
        check("do_out", 1'b0, do_out);
        cyc(35);
        check("do_out", 1'b1, do_out);
        check("relay_out", 1'b0, relay_out);
        // Lower limit side: its own delay must elapse before the relay reports it.
        out_freq = 16'h03e8;
        cyc(25);
        check("relay_out", 1'b0, relay_out);
        cyc(35);
        check("relay_out", 1'b1, relay_out);
        check("do_out", 1'b0, do_out);
    endtask : scen_limit_delay

    task automatic scen_underload();
        do_function = 6'h23;
        out_torque  = 12'h032;
        cyc(25);
        check("do_out", 1'b0, do_out);
        cyc(35);
        check("do_out", 1'b1, do_out);
        out_torque = 12'h064;
        cyc(4);
        check("do_out", 1'b1, do_out);
        out_torque = 12'h065;
        cyc(4);
        check("do_out", 1'b0, do_out);
        // A threshold above 200.0 percent saturates, so torque just over it is no underload.
        underload_threshold = 12'hfff;
        out_torque          = 12'h7d1;
        cyc(60);
        check("do_out", 1'b0, do_out);
    endtask : scen_underload

    task automatic scen_timing();
        int n;
        n = 0;
        do_function   = 6'h06;
        timing_enable = 1'b1;
        while (timing_value !== 16'h0003 && n < 200) begin
            cyc(1);
            n++;
        end
        if (n >= 200) begin
            mismatches++;
            final_report();
        end
        cyc(3);
        check("do_out", 1'b1, do_out);
        cyc(15);
        check("do_out", 1'b0, do_out);
        timing_enable = 1'b0;
        cyc(3);
        check("timing_value", 16'h0000, timing_value);
        timing_unit_min = 1'b1;
        timing_enable   = 1'b1;
        cyc(300);
        check("timing_value", 16'h0000, timing_value);
        cyc(350);
        check("timing_value", 16'h0001, timing_value);
    endtask : scen_timing

    // ****************************************************************
    // Main sequence.
    // ****************************************************************
    initial begin
        repeat (4) @(posedge mclk);
        @(negedge mclk);
        rst_b = 1'b1;
        cyc(2);
        scen_freq();
        scen_torque_count();
        scen_limit_delay();
        scen_underload();
        scen_timing();
        final_report();
    end
endmodule : test_docm_top
